//--- rtl/cssr_pkg.sv
// Constants and carriers for clock select, start-up and reset sequencing.
// Assumes a single 10 MHz system clock and watchdog/oscillator ticks as pin inputs.
package cssr_pkg;

   localparam logic [3:0] CSSR_CKS_RESET = 4'h2;
   localparam logic [1:0] CSSR_SUT_RESET = 2'h2;
   localparam logic CSSR_DIV8_RESET = 1'b0;
   localparam logic CSSR_PROGRAMMED = 1'b0;

   localparam int CSSR_CW = 16;
   localparam logic [15:0] CSSR_TOUT_SHORT = 16'h0200;
   localparam logic [15:0] CSSR_TOUT_LONG = 16'h2000;
   localparam logic [15:0] CSSR_SU_EXT = 16'h0006;
   localparam logic [15:0] CSSR_SU_258 = 16'h0102;
   localparam logic [15:0] CSSR_SU_1K = 16'h0400;
   localparam logic [15:0] CSSR_SU_16K = 16'h4000;
   localparam logic [15:0] CSSR_SU_32K = 16'h8000;
   localparam logic [15:0] CSSR_SU_RESET_ADD = 16'h000e;
   localparam logic [2:0] CSSR_DIV8_LAST = 3'h7;

   typedef enum logic [2:0]
   {
      CSSR_SRC_EXT = 3'h0,
      CSSR_SRC_RC128 = 3'h1,
      CSSR_SRC_RCCAL = 3'h2,
      CSSR_SRC_LFXTAL = 3'h3,
      CSSR_SRC_FSXTAL = 3'h4,
      CSSR_SRC_LPXTAL = 3'h5,
      CSSR_SRC_RSVD = 3'h6
   } cssr_src_t;

   typedef struct packed
   {
      logic [3:0] clock_source_select;
      logic [1:0] startup_time_select;
      logic divide_by_eight_bit;
   } cssr_cfg_t;

   // Per-domain run enables; one bit per clock domain
   typedef struct packed
   {
      logic core_clock;
      logic peripheral_clock;
      logic program_memory_clock;
      logic async_timer_clock;
      logic converter_clock;
   } cssr_gate_t;

endpackage : cssr_pkg

//--- rtl/cssr_tick_counter.sv
// Down-counter of qualified ticks with a done flag.
// Assumes tick is already synchronised to clk; load wins over counting.
module cssr_tick_counter
   import cssr_pkg::*;
#(
   parameter int W = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] count,
   input wire logic tick,
   // Status
   output logic done
);
   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic run;
   } cssr_tc_t;

   cssr_tc_t s_q;
   cssr_tc_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (load)
      begin
         s_d.cnt = count;
         s_d.run = 1'b1;
      end
      else if (s_q.run && s_q.cnt == '0)
      begin
         s_d.run = 1'b0;
      end
      else if (s_q.run && tick)
      begin
         s_d.cnt = s_q.cnt - W'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Zero count finishes one cycle after load, so zero time-out works
   assign done = s_q.run && s_q.cnt == '0;
endmodule : cssr_tick_counter

//--- rtl/cssr_sync.sv
// Two-flop synchroniser and rising-edge pulse for one pin input.
// Assumes the input is asynchronous to clk.
module cssr_sync
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pin and results
   input wire logic pin,
   output logic level,
   output logic rise
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
   } cssr_sy_t;

   cssr_sy_t s_q;
   cssr_sy_t s_d;

   always_comb
   begin
      s_d.s1 = pin;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign level = s_q.s2;
   assign rise = s_q.s2 && !s_q.s3;
endmodule : cssr_sync

//--- rtl/cssr_clock_control.sv
// Clock source decode, start-up sequencing, internal reset and domain gates.
// Assumes oscillator and watchdog ticks arrive as asynchronous pin levels.
module cssr_clock_control
   import cssr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Other reset sources, active low level
   input wire logic other_reset_n,
   // Nonvolatile configuration
   input cssr_pkg::cssr_cfg_t cfg,
   // Oscillator and watchdog oscillator ticks
   input wire logic osc_tick,
   input wire logic wdt_tick,
   // Sleep control
   input cssr_pkg::cssr_gate_t sleep_gate_off,
   input wire logic deep_sleep,
   input wire logic wake,
   // Asynchronous event sources
   input wire logic two_wire_addr_match,
   input wire logic async_int_pin,
   // Outputs
   output cssr_pkg::cssr_gate_t clock_run,
   output logic clock_tick,
   output logic internal_reset_n,
   output cssr_pkg::cssr_src_t source,
   output logic source_reserved,
   output logic wake_event
);
   import cssr_pkg::*;

   typedef enum logic [4:0]
   {
      ST_HOLD = 5'h01,
      ST_TOUT = 5'h02,
      ST_START = 5'h04,
      ST_RUN = 5'h08,
      ST_SLEEP = 5'h10
   } cssr_state_t;

   typedef struct packed
   {
      cssr_state_t st;
      cssr_cfg_t cfg;
      cssr_src_t src;
      logic [15:0] su;
      logic [15:0] tout;
      logic load_tout;
      logic load_su;
      logic [2:0] div;
      logic tick;
      cssr_gate_t run;
      logic rst_n;
   } cssr_s_t;

   cssr_s_t s_q;
   cssr_s_t s_d;

   logic other_lvl;
   logic osc_rise;
   logic wdt_rise;
   logic tout_done;
   logic su_done;
   logic two_lvl;
   logic aint_lvl;

   cssr_sync u_sync_rst
   (
      .clk(clk),
      .nrst(nrst),
      .pin(other_reset_n),
      .level(other_lvl),
      .rise()
   );

   cssr_sync u_sync_osc
   (
      .clk(clk),
      .nrst(nrst),
      .pin(osc_tick),
      .level(),
      .rise(osc_rise)
   );

   cssr_sync u_sync_wdt
   (
      .clk(clk),
      .nrst(nrst),
      .pin(wdt_tick),
      .level(),
      .rise(wdt_rise)
   );

   cssr_sync u_sync_two
   (
      .clk(clk),
      .nrst(nrst),
      .pin(two_wire_addr_match),
      .level(two_lvl),
      .rise()
   );

   cssr_sync u_sync_aint
   (
      .clk(clk),
      .nrst(nrst),
      .pin(async_int_pin),
      .level(aint_lvl),
      .rise()
   );

   // Time-out counted on watchdog ticks
   cssr_tick_counter #(.W(CSSR_CW)) u_tout
   (
      .clk(clk),
      .nrst(nrst),
      .load(s_q.load_tout),
      .count(s_q.tout),
      .tick(wdt_rise),
      .done(tout_done)
   );

   // Stands in for the ripple counter on oscillator edges
   cssr_tick_counter #(.W(CSSR_CW)) u_su
   (
      .clk(clk),
      .nrst(nrst),
      .load(s_q.load_su),
      .count(s_q.su),
      .tick(osc_rise),
      .done(su_done)
   );

   function automatic cssr_src_t decode(input logic [3:0] c);
      cssr_src_t r;
      r = CSSR_SRC_RSVD;
      if (c[3])
      begin
         r = CSSR_SRC_LPXTAL;
      end
      else if (c[2:1] == 2'h3)
      begin
         r = CSSR_SRC_FSXTAL;
      end
      else if (c[2:1] == 2'h2)
      begin
         r = CSSR_SRC_LFXTAL;
      end
      else
      begin
         case (c[1:0])
            2'h3: r = CSSR_SRC_RC128;
            2'h2: r = CSSR_SRC_RCCAL;
            2'h0: r = CSSR_SRC_EXT;
            default: r = CSSR_SRC_RSVD;
         endcase
      end
      return r;
   endfunction : decode

   // Start-up count on oscillator cycles, per source and start-up bits
   function automatic logic [15:0] su_count(input cssr_src_t s, input cssr_cfg_t f);
      logic [2:0] k;
      logic [15:0] r;
      k = {f.clock_source_select[0], f.startup_time_select};
      r = CSSR_SU_EXT;
      case (s)
         CSSR_SRC_LPXTAL, CSSR_SRC_FSXTAL:
         begin
            if (k < 3'h2)
            begin
               r = CSSR_SU_258;
            end
            else if (k < 3'h5)
            begin
               r = CSSR_SU_1K;
            end
            else
            begin
               r = CSSR_SU_16K;
            end
         end
         CSSR_SRC_LFXTAL: r = CSSR_SU_32K;
         default: r = CSSR_SU_EXT;
      endcase
      return r;
   endfunction : su_count

   // Source bit 0 and startup bits select a time-out of 0 or 512 or 8192 watchdog cycles
   function automatic logic [15:0] tout_count(input cssr_cfg_t f);
      logic [15:0] r;
      logic [2:0] k;
      k = {f.clock_source_select[0], f.startup_time_select};
      case (k)
         3'h2, 3'h5: r = '0;
         3'h0, 3'h3, 3'h6: r = CSSR_TOUT_SHORT;
         default: r = CSSR_TOUT_LONG;
      endcase
      return r;
   endfunction : tout_count

   always_comb
   begin
      s_d = s_q;
      s_d.load_tout = 1'b0;
      s_d.load_su = 1'b0;
      s_d.rst_n = 1'b0;
      s_d.div = s_q.div;
      case (s_q.st)
         ST_HOLD:
         begin
            s_d.cfg = cfg;
            s_d.src = decode(cfg.clock_source_select);
            s_d.su = su_count(decode(cfg.clock_source_select), cfg);
            s_d.tout = tout_count(cfg);
            if (other_lvl)
            begin
               s_d.st = ST_TOUT;
               s_d.load_tout = 1'b1;
            end
         end
         ST_TOUT:
         begin
            if (tout_done && !s_q.load_tout)
            begin
               s_d.st = ST_START;
               // Reset adds 14 cycles on low-power and full-swing crystal sources, not on the low-frequency crystal
               s_d.su = (s_q.src == CSSR_SRC_LPXTAL || s_q.src == CSSR_SRC_FSXTAL) ?
                  s_q.su + CSSR_SU_RESET_ADD : s_q.su;
               s_d.load_su = 1'b1;
            end
         end
         ST_START:
         begin
            // Deep wake keeps the core out of reset; only its clocks wait
            s_d.rst_n = s_q.rst_n;
            if (su_done && !s_q.load_su)
            begin
               s_d.st = ST_RUN;
               s_d.rst_n = 1'b1;
            end
         end
         ST_RUN:
         begin
            s_d.rst_n = 1'b1;
            if (deep_sleep)
            begin
               s_d.st = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            s_d.rst_n = 1'b1;
            if (wake || aint_lvl || two_lvl)
            begin
               // Deep wake skips the time-out; supply assumed good
               s_d.st = ST_START;
               s_d.su = su_count(s_q.src, s_q.cfg);
               s_d.load_su = 1'b1;
            end
         end
         default:
         begin
            s_d.st = ST_HOLD;
         end
      endcase
      if (!other_lvl)
      begin
         s_d.st = ST_HOLD;
         s_d.rst_n = 1'b0;
      end
      // Divider runs on oscillator edges
      s_d.tick = 1'b0;
      if (osc_rise)
      begin
         if (s_q.cfg.divide_by_eight_bit == CSSR_PROGRAMMED)
         begin
            s_d.div = s_q.div + 3'h1;
            s_d.tick = (s_q.div == CSSR_DIV8_LAST);
         end
         else
         begin
            s_d.tick = 1'b1;
         end
      end
      s_d.run.core_clock = s_d.rst_n && !sleep_gate_off.core_clock
         && s_d.st == ST_RUN;
      s_d.run.program_memory_clock = s_d.run.core_clock;
      s_d.run.peripheral_clock = s_d.rst_n && !sleep_gate_off.peripheral_clock
         && s_d.st == ST_RUN;
      // Converter keeps running when core and peripheral halt
      s_d.run.converter_clock = s_d.rst_n && !sleep_gate_off.converter_clock;
      s_d.run.async_timer_clock = s_d.rst_n && !sleep_gate_off.async_timer_clock;
      // Each domain gated on its own bit, except program memory, which follows the core clock
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q.st <= ST_HOLD;
         s_q.cfg <= '{CSSR_CKS_RESET, CSSR_SUT_RESET, CSSR_DIV8_RESET};
         s_q.src <= CSSR_SRC_RCCAL;
         s_q.su <= CSSR_SU_EXT;
         s_q.tout <= CSSR_TOUT_LONG;
         s_q.load_tout <= 1'b0;
         s_q.load_su <= 1'b0;
         s_q.div <= '0;
         s_q.tick <= 1'b0;
         s_q.run <= '0;
         s_q.rst_n <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign clock_run = s_q.run;
   assign clock_tick = s_q.tick;
   assign internal_reset_n = s_q.rst_n;
   assign source = s_q.src;
   assign source_reserved = (s_q.src == CSSR_SRC_RSVD);
   // Async wake sources seen without any gated clock
   assign wake_event = aint_lvl || two_lvl;
endmodule : cssr_clock_control

//--- sim/cssr_checker.sv
// Port checker for the clock control block.
// Assumes one clock domain; bound to the clock control module at the foot.
module cssr_checker
   import cssr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Watched inputs
   input wire logic other_reset_n,
   input wire logic two_wire_addr_match,
   input wire logic async_int_pin,
   // Watched outputs
   input cssr_pkg::cssr_gate_t clock_run,
   input wire logic clock_tick,
   input wire logic internal_reset_n,
   input cssr_pkg::cssr_src_t source,
   input wire logic source_reserved,
   input wire logic wake_event
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);

   rsvd_flag_a: assert property (source_reserved == (source == CSSR_SRC_RSVD))
      else $error("reserved flag disagrees with source");
   tick_pulse_a: assert property (clock_tick |=> !clock_tick)
      else $error("clock tick longer than one cycle");
   reset_hold_a: assert property (!other_reset_n [*4] |-> !internal_reset_n)
      else $error("internal reset not held");
   release_cause_a: assert property ($rose(internal_reset_n)
      |-> other_reset_n && $past(other_reset_n, 3))
      else $error("release without other reset gone");
   core_gate_a: assert property (!internal_reset_n [*2] |-> !clock_run.core_clock)
      else $error("core clock runs in reset");
   flash_core_a: assert property (clock_run.program_memory_clock == clock_run.core_clock)
      else $error("program memory clock apart from core");
   src_hold_a: assert property (internal_reset_n [*2] |-> $stable(source))
      else $error("source changed while running");
   int_wake_a: assert property (async_int_pin [*3] |-> wake_event)
      else $error("async pin did not wake");
   addr_wake_a: assert property (two_wire_addr_match [*3] |-> wake_event)
      else $error("address match did not wake");
endmodule : cssr_checker

bind cssr_clock_control cssr_checker u_cssr_checker (.clk(clk), .nrst(nrst),
   .other_reset_n(other_reset_n), .two_wire_addr_match(two_wire_addr_match),
   .async_int_pin(async_int_pin), .clock_run(clock_run), .clock_tick(clock_tick),
   .internal_reset_n(internal_reset_n), .source(source),
   .source_reserved(source_reserved), .wake_event(wake_event));

//--- sim/cssr_osc_model.sv
// Oscillator and watchdog oscillator tick source.
// Assumes edges launched 5 ns after clk; half period of at least 2 cycles.
module cssr_osc_model
(
   // Clock
   input wire logic clk,
   // Tick pins
   output logic osc_tick,
   output logic wdt_tick
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      {wdt_tick, osc_tick} = 2'h0;
   end

   // Stands still between bursts so every counted edge is one we asked for
   task automatic pulses(input logic wd, input int n, input int half);
      for (int i = 0; i < n; i++)
      begin
         repeat (half) @(posedge clk);
         #5;
         {wdt_tick, osc_tick} = wd ? 2'h2 : 2'h1;
         repeat (half) @(posedge clk);
         #5;
         {wdt_tick, osc_tick} = 2'h0;
      end
   endtask : pulses
endmodule : cssr_osc_model

//--- sim/clock_select_startup_reset_bench.sv
// Bench: start-up counts, source decode, divider, gates and wake.
// Assumes the tick model drives the oscillator pins.
module clock_select_startup_reset_bench
   import cssr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, nrst, other_reset_n, deep_sleep, wake, two_wire_addr_match, async_int_pin;
   logic osc_tick, wdt_tick, clock_tick, internal_reset_n, source_reserved, wake_event;
   cssr_cfg_t cfg;
   cssr_gate_t sleep_gate_off, clock_run, g;
   cssr_src_t source;
   int err_count, cmp_count, cyc, ticks, seed;
   cssr_cfg_t cases[7] = '{7'h05, 7'h14, 7'h1b, 7'h0a, 7'h31, 7'h70, 7'h45};

   cssr_clock_control u_cssr_clock_control (.clk(clk), .nrst(nrst),
      .other_reset_n(other_reset_n), .cfg(cfg), .osc_tick(osc_tick), .wdt_tick(wdt_tick),
      .sleep_gate_off(sleep_gate_off), .deep_sleep(deep_sleep), .wake(wake),
      .two_wire_addr_match(two_wire_addr_match), .async_int_pin(async_int_pin),
      .clock_run(clock_run), .clock_tick(clock_tick), .internal_reset_n(internal_reset_n),
      .source(source), .source_reserved(source_reserved), .wake_event(wake_event));
   cssr_osc_model u_cssr_osc_model (.clk(clk), .osc_tick(osc_tick), .wdt_tick(wdt_tick));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (clock_tick === 1'b1)
         ticks <= ticks + 1;
      if (cyc == 60000)
      begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : step

   function automatic cssr_src_t src_of(input logic [3:0] s);
      case (s)
         4'h0: return CSSR_SRC_EXT;
         4'h1: return CSSR_SRC_RSVD;
         4'h2: return CSSR_SRC_RCCAL;
         4'h3: return CSSR_SRC_RC128;
         4'h4, 4'h5: return CSSR_SRC_LFXTAL;
         4'h6, 4'h7: return CSSR_SRC_FSXTAL;
         default: return CSSR_SRC_LPXTAL;
      endcase
   endfunction : src_of

   task automatic run_case(input cssr_cfg_t c, input int half, input int i);
      int k;
      int t;
      int s;
      int x;
      int t0;
      k = {c.clock_source_select[0], c.startup_time_select};
      t = (k == 2 || k == 5) ? 0 : (k % 3 == 0) ? 512 : 8192;
      x = (c.clock_source_select > 4'h5) ? 14 : 0;
      s = (x == 0) ? 6 : (k < 2 ? 258 : k < 5 ? 1024 : 16384);
      if (c.clock_source_select[3:1] == 3'h2)
         s = 32768;
      {nrst, other_reset_n} = 2'h0;
      cfg = c;
      step(5);
      nrst = 1'b1;
      step(3);
      other_reset_n = 1'b1;
      if (t > 0)
      begin
         // Oscillator edges during the time-out must not count
         u_cssr_osc_model.pulses(1'b1, t - 1, half);
         u_cssr_osc_model.pulses(1'b0, s + x, half);
         step(8);
         chk(internal_reset_n, 1'b0);
         u_cssr_osc_model.pulses(1'b1, 1, half);
         step(4);
      end
      else
         step(8); // Start-up counter must be loaded before the first edge
      u_cssr_osc_model.pulses(1'b0, s + x - 1, half);
      step(8);
      chk(internal_reset_n, 1'b0);
      u_cssr_osc_model.pulses(1'b0, 1, half);
      step(8);
      chk(internal_reset_n, 1'b1);
      chk(source, src_of(c.clock_source_select));
      chk(source_reserved, c.clock_source_select == 4'h1);
      cfg = 7'($random(seed));
      t0 = ticks;
      u_cssr_osc_model.pulses(1'b0, 16, half);
      step(4);
      chk(16'(ticks - t0), c.divide_by_eight_bit ? 16'h0010 : 16'h0002);
      chk(source, src_of(c.clock_source_select));
      g = 5'($random(seed));
      g.program_memory_clock = g.core_clock;
      sleep_gate_off = g;
      step(4);
      chk(clock_run, 5'(~g));
      sleep_gate_off = '0;
      deep_sleep = 1'b1;
      step(6);
      chk(clock_run, 5'h03);
      deep_sleep = 1'b0;
      {wake, two_wire_addr_match, async_int_pin} = (i % 3 == 0) ? 3'h4 : (i % 2) ? 3'h2 : 3'h1;
      step(4);
      chk(wake_event, i % 3 != 0);
      chk(internal_reset_n, 1'b1);
      {wake, two_wire_addr_match, async_int_pin} = 3'h4;
      // No watchdog ticks here: a wake that waits for the time-out hangs
      u_cssr_osc_model.pulses(1'b0, s - 1, half);
      step(8);
      chk(clock_run.core_clock, 1'b0);
      u_cssr_osc_model.pulses(1'b0, 1, half);
      wake = 1'b0;
      step(8);
      chk(clock_run.core_clock, 1'b1);
      other_reset_n = 1'b0;
      step(5);
      chk(internal_reset_n, 1'b0);
   endtask : run_case

   initial
   begin
      seed = 15156;
      {err_count, cmp_count, cyc, ticks} = '0;
      {nrst, other_reset_n, deep_sleep, wake, two_wire_addr_match, async_int_pin} = '0;
      cfg = '0;
      sleep_gate_off = '0;
      step(5);
      foreach (cases[i])
         run_case(cases[i], 2 + i % 2, i);
      end_sim();
   end
endmodule : clock_select_startup_reset_bench
